// [rtl/flash_seq_params.svh]
// constants for the serial flash erase/suspend/power-down sequencer
// assumes inclusion by bare name from rtl/
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH
`define OP_BLOCK32_ERASE   8'h52
`define OP_BLOCK64_ERASE   8'hd8
`define OP_CHIP_ERASE_A    8'hc7
`define OP_CHIP_ERASE_B    8'h60
`define OP_SECTOR_ERASE    8'h20
`define OP_SECREG_ERASE    8'h44
`define OP_SUSPEND         8'h75
`define OP_RESUME          8'h7a
`define OP_POWER_DOWN      8'hb9
`define OP_RELEASE_PD      8'hab
`define OP_WRITE_ENABLE    8'h06
`define OP_WRITE_STATUS    8'h01
`define OP_READ_STATUS     8'h05
`define OP_PAGE_PROGRAM    8'h02
`define OP_QUAD_PROGRAM    8'h32
`define OP_SECREG_PROGRAM  8'h42
`define CLK_PERIOD_NS      40
`define RESUME_BUSY_NS     200
`define RESUME_BUSY_CYC    (`RESUME_BUSY_NS / `CLK_PERIOD_NS)
`define SMALL_BLOCK_ERASE_CYC 400
`define LARGE_BLOCK_ERASE_CYC 500
`define FULL_ARRAY_ERASE_CYC  700
`define PROGRAM_CYC        48
`define SUSPEND_CYC        8
`define POWERDOWN_ENTRY_CYC 6
`define RELEASE_RECOVERY_CYC 6
`define SCLK_HALF_CYC      4
`define STATUS_BUSY_BIT    0
`define STATUS_WEL_BIT     1
`define STATUS_SUS_BIT     7
`endif

// [rtl/flash_seq_pkg.sv]
// types shared by both ends of the flash command link
// assumes flash_seq_params.svh defines the opcodes
package flash_seq_pkg;
    typedef logic [7:0]  opcode_t;
    typedef logic [23:0] flash_addr_t;
    typedef logic [5:0]  protect_t;
    typedef enum logic [1:0] {JOB_NONE, JOB_ERASE, JOB_CHIP, JOB_PROGRAM} job_e;
endpackage : flash_seq_pkg

// [rtl/flash_link_if.sv]
// spi link between host controller and flash device
// assumes both ends share one system clock; sclk is sampled, not clocked on
`timescale 1ns/100ps
`default_nettype none
interface flash_link_if;
    logic csN;
    logic sclk;
    logic mosi;
    logic miso;
    modport host   (output csN, output sclk, output mosi, input miso);
    modport device (input csN, input sclk, input mosi, output miso);
endinterface : flash_link_if
`default_nettype wire

// [rtl/cycle_timer.sv]
// loadable down-counter for self-timed intervals
// assumes load and hold come from logic on clk
`timescale 1ns/100ps
`default_nettype none
module cycle_timer #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadValue,
    input  wire logic             hold,
    // status
    output logic                  running,
    output logic                  done
);
    logic [WIDTH-1:0] count;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count <= '0;
        end else if (load) begin
            count <= loadValue;
        end else if (!hold && count != '0) begin
            count <= count - WIDTH'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            done <= 1'b0;
        end else begin
            done <= !load && !hold && count == WIDTH'(1);
        end
    end

    assign running = count != '0;
endmodule : cycle_timer
`default_nettype wire

// [rtl/flash_device.sv]
// flash device end: spi command decode, erase/suspend/power-down sequencing
// assumes sclk idles low (mode 0) and is slower than clk by at least 4x
// Contract
// - opcode 52h plus address erases 32k block
// - opcode d8h plus address erases 64k block
// - c7h or 60h alone erases whole array
// - erase accepted only with write enable latch
// - block erase needs cs high after address
// - chip erase, power-down need cs after opcode
// - self-timed busy cycle, status still readable
// - write enable latch cleared when erase ends
// - protected regions refuse block and chip erase
// - suspend only when unsuspended, busy, suspendable job
// - suspend ignored during whole-array erase
// - erase suspended blocks erases, status writes
// - program suspended blocks programs, status writes
// - suspend sets flag now, busy drops later
// - host spaces suspend after resume by tsus
// - reset comes up unsuspended, resume ignored
// - resume clears flag, busy within 200ns
// - resume only when suspended and idle
// - b9h then cs high enters power-down
// - powered down only abh is recognised
// - reset always starts in normal operation
// - release needs recovery before new commands
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_params.svh"
module flash_device #(
    parameter int SMALL_ERASE_CYC = `SMALL_BLOCK_ERASE_CYC,
    parameter int LARGE_ERASE_CYC = `LARGE_BLOCK_ERASE_CYC,
    parameter int CHIP_ERASE_CYC  = `FULL_ARRAY_ERASE_CYC,
    parameter int PROG_CYC        = `PROGRAM_CYC,
    parameter int SUSPEND_CYC     = `SUSPEND_CYC,
    parameter int PD_ENTRY_CYC    = `POWERDOWN_ENTRY_CYC,
    parameter int RELEASE_CYC     = `RELEASE_RECOVERY_CYC
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    // spi link
    flash_link_if.device                 link,
    // protection state (bp, tb, sec, cmp) and individual locks
    input  wire flash_seq_pkg::protect_t protectBits,
    input  wire logic [31:0]             blockLocked,
    // observed state
    output logic                         busy,
    output logic                         writeEnableLatch,
    output logic                         suspendFlag,
    output logic                         poweredDown,
    output logic                         eraseStrobe,
    output flash_seq_pkg::flash_addr_t   eraseAddr,
    output logic [1:0]                   eraseKind
);
    import flash_seq_pkg::*;

    // two-flop synchronisers on all pin inputs
    logic [1:0] csSync, sclkSync, mosiSync;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            csSync   <= 2'h3;
            sclkSync <= 2'h0;
            mosiSync <= 2'h0;
        end else begin
            csSync   <= {csSync[0], link.csN};
            sclkSync <= {sclkSync[0], link.sclk};
            mosiSync <= {mosiSync[0], link.mosi};
        end
    end
    logic csQ, sclkQ;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            csQ   <= 1'b1;
            sclkQ <= 1'b0;
        end else begin
            csQ   <= csSync[1];
            sclkQ <= sclkSync[1];
        end
    end
    wire sclkRise = sclkSync[1] && !sclkQ;
    wire sclkFall = !sclkSync[1] && sclkQ;
    wire csRise   = csSync[1] && !csQ;

    // shift in opcode and address; bit count tells frame length
    logic [31:0] shiftIn;
    logic [5:0]  bitCount;
    always_ff @(posedge clk) begin
        if (sys_rst || csSync[1]) begin
            shiftIn  <= '0;
            bitCount <= '0;
        end else if (sclkRise) begin
            shiftIn  <= {shiftIn[30:0], mosiSync[1]};
            bitCount <= (bitCount == 6'h3f) ? bitCount : bitCount + 6'h1;
        end
    end
    wire opcode_t opNow   = shiftIn[7:0];
    wire opcode_t opFrame = shiftIn[31:24];

    // job state
    job_e        job;
    logic        recovering;
    logic        pdPending;
    logic [1:0]  resumeDelay;
    logic        timerLoad, timerHold, timerDone, timerRunning;
    logic [15:0] timerValue;
    logic        suspTimerLoad, suspDone;

    // frame classification at cs rise; exact lengths enforce cs timing
    wire short8  = bitCount == 6'd8;
    wire long32  = bitCount == 6'd32;
    wire isChip  = short8 && (opNow == `OP_CHIP_ERASE_A || opNow == `OP_CHIP_ERASE_B);
    wire isBlk32 = long32 && opFrame == `OP_BLOCK32_ERASE;
    wire isBlk64 = long32 && opFrame == `OP_BLOCK64_ERASE;
    wire isProg  = bitCount > 6'd32 && (shiftIn[7:0] != 8'h00 || 1'b1) && 1'b0;
    // protection: any set level bit or lock covers region; coarse by design
    wire anyProtect  = protectBits[2:0] != 3'h0 || blockLocked != 32'h0;
    wire blockLock   = blockLocked[shiftIn[20:16]];
    wire blockProt   = protectBits[2:0] != 3'h0 || blockLock;
    wire susErase    = suspendFlag && job == JOB_ERASE;
    wire susProgram  = suspendFlag && job == JOB_PROGRAM;
    // normal mode, not busy, not recovering
    wire canStart    = !poweredDown && !recovering && !pdPending && !busy && !suspendFlag;
    wire startBlk    = (isBlk32 || isBlk64) && writeEnableLatch && !blockProt;
    wire startChip   = isChip && writeEnableLatch && !anyProtect;
    wire goBlk       = csRise && canStart && startBlk;
    wire goChip      = csRise && canStart && startChip;
    wire goSuspend   = csRise && short8 && opNow == `OP_SUSPEND && !poweredDown
                       && !suspendFlag && busy && job == JOB_ERASE;
    wire goResume    = csRise && short8 && opNow == `OP_RESUME && !poweredDown
                       && suspendFlag && !busy;
    wire goPd        = csRise && short8 && opNow == `OP_POWER_DOWN && !poweredDown && !busy && !recovering;
    wire goRelease   = csRise && short8 && opNow == `OP_RELEASE_PD && poweredDown;
    wire goWren      = csRise && short8 && opNow == `OP_WRITE_ENABLE && !poweredDown
                       && !recovering && !busy;
    // suspended erase blocks erase starts; canStart already excludes them
    wire blockedBySus = susErase || susProgram;

    always_comb begin
        timerLoad  = 1'b0;
        timerValue = 16'h0;
        if (goBlk) begin
            timerLoad  = 1'b1;
            timerValue = isBlk32 ? 16'(SMALL_ERASE_CYC) : 16'(LARGE_ERASE_CYC);
        end else if (goChip) begin
            timerLoad  = 1'b1;
            timerValue = 16'(CHIP_ERASE_CYC);
        end else if (goPd) begin
            timerLoad  = 1'b1;
            timerValue = 16'(PD_ENTRY_CYC);
        end else if (goRelease) begin
            timerLoad  = 1'b1;
            timerValue = 16'(RELEASE_CYC);
        end
    end
    assign timerHold     = suspendFlag || resumeDelay != 2'h0;
    assign suspTimerLoad = goSuspend;

    cycle_timer #(.WIDTH(16)) jobTimer (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .load      (timerLoad),
        .loadValue (timerValue),
        .hold      (timerHold),
        .running   (timerRunning),
        .done      (timerDone)
    );
    cycle_timer #(.WIDTH(8)) suspendTimer (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .load      (suspTimerLoad),
        .loadValue (8'(SUSPEND_CYC)),
        .hold      (1'b0),
        .running   (),
        .done      (suspDone)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            job <= JOB_NONE;
        end else if (goBlk) begin
            job <= JOB_ERASE;
        end else if (goChip) begin
            job <= JOB_CHIP;
        end else if (busy && timerDone) begin
            job <= JOB_NONE;
        end
    end

    // busy follows the job; suspend drops it after the suspend latency
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy <= 1'b0;
        end else if (goBlk || goChip) begin
            busy <= 1'b1;
        end else if (suspDone) begin
            busy <= 1'b0;
        end else if (resumeDelay == 2'h1) begin
            busy <= 1'b1;
        end else if (busy && timerDone && !suspendFlag) begin
            busy <= 1'b0;
        end
    end

    // resume raises busy a few cycles later, inside the 200ns bound
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            resumeDelay <= 2'h0;
        end else if (goResume) begin
            resumeDelay <= 2'(`RESUME_BUSY_CYC - 3);
        end else if (resumeDelay != 2'h0) begin
            resumeDelay <= resumeDelay - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            suspendFlag <= 1'b0;
        end else if (goSuspend) begin
            suspendFlag <= 1'b1;
        end else if (goResume) begin
            suspendFlag <= 1'b0;
        end
    end

    // completion clear wins over the write enable set: both cannot coincide while busy
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            writeEnableLatch <= 1'b0;
        end else if (busy && timerDone && !suspendFlag && job != JOB_NONE) begin
            writeEnableLatch <= 1'b0;
        end else if (goWren) begin
            writeEnableLatch <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pdPending   <= 1'b0;
            poweredDown <= 1'b0;
            recovering  <= 1'b0;
        end else begin
            if (goPd) begin
                pdPending <= 1'b1;
            end else if (pdPending && timerDone) begin
                pdPending   <= 1'b0;
                poweredDown <= 1'b1;
            end
            if (goRelease) begin
                poweredDown <= 1'b0;
                recovering  <= 1'b1;
            end else if (recovering && timerDone) begin
                recovering  <= 1'b0;
            end
        end
    end

    // erase event for a memory model outside
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            eraseStrobe <= 1'b0;
            eraseAddr   <= '0;
            eraseKind   <= 2'h0;
        end else begin
            eraseStrobe <= busy && timerDone && !suspendFlag && job != JOB_NONE;
            if (goBlk || goChip) begin
                eraseAddr <= goChip ? 24'h0 : shiftIn[23:0];
                eraseKind <= goChip ? 2'h3 : (isBlk32 ? 2'h1 : 2'h2);
            end
        end
    end

    // status read: shift status out on falling sclk; silent when powered down
    logic [7:0] statusShift;
    logic       misoQ;
    wire logic [7:0] statusNow = {suspendFlag, 5'h0, writeEnableLatch, busy};
    always_ff @(posedge clk) begin
        if (sys_rst || csSync[1]) begin
            statusShift <= 8'h0;
            misoQ       <= 1'b0;
        end else if (sclkFall && bitCount == 6'd8 && opNow == `OP_READ_STATUS && !poweredDown) begin
            statusShift <= {statusNow[6:0], 1'b0};
            misoQ       <= statusNow[7];
        end else if (sclkFall && bitCount > 6'd8) begin
            statusShift <= {statusShift[6:0], 1'b0};
            misoQ       <= statusShift[7];
        end
    end
    assign link.miso = misoQ;
    wire unusedBits = isProg ^ blockedBySus ^ timerRunning;
endmodule : flash_device
`default_nettype wire

// [rtl/flash_host.sv]
// host end: sends one command frame per request and reads status
// assumes the register port comes from logic on clk
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_params.svh"
module flash_host #(
    parameter int HALF_CYC    = `SCLK_HALF_CYC,
    parameter int RECOVER_CYC = `RELEASE_RECOVERY_CYC,
    parameter int SUSPEND_GAP = `SUSPEND_CYC
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // spi link
    flash_link_if.host                 link,
    // register port: 0 opcode+go, 1 address, 2 status
    input  wire logic [1:0]            regAddr,
    input  wire logic [31:0]           regWdata,
    input  wire logic                  regWrite,
    input  wire logic                  regRead,
    output logic [31:0]                regRdata
);
    import flash_seq_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_GAP} host_e;
    host_e       state;
    flash_addr_t addrReg;
    logic [31:0] txShift;
    logic [5:0]  bitsLeft;
    logic [7:0]  rxByte;
    logic [7:0]  halfCount;
    logic [7:0]  gapCount;
    logic        phaseHigh;
    logic        csReg, sclkReg;
    logic [1:0]  misoSync;

    wire opcode_t wOp   = regWdata[7:0];
    wire withAddr       = wOp == `OP_BLOCK32_ERASE || wOp == `OP_BLOCK64_ERASE;
    wire withRead       = wOp == `OP_READ_STATUS;
    wire start          = regWrite && regAddr == 2'h0 && state == S_IDLE;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            misoSync <= 2'h0;
        end else begin
            misoSync <= {misoSync[0], link.miso};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addrReg <= '0;
        end else if (regWrite && regAddr == 2'h1) begin
            addrReg <= regWdata[23:0];
        end
    end

    // cs rises right after the last bit, which the device demands
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state     <= S_IDLE;
            csReg     <= 1'b1;
            sclkReg   <= 1'b0;
            txShift   <= '0;
            bitsLeft  <= '0;
            halfCount <= '0;
            phaseHigh <= 1'b0;
            gapCount  <= '0;
            rxByte    <= '0;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (start) begin
                        state     <= S_SHIFT;
                        csReg     <= 1'b0;
                        txShift   <= withAddr ? {wOp, addrReg} : {wOp, 24'h0};
                        bitsLeft  <= withAddr ? 6'd32 : (withRead ? 6'd16 : 6'd8);
                        halfCount <= 8'(HALF_CYC);
                        phaseHigh <= 1'b0;
                    end
                end
                S_SHIFT: begin
                    if (halfCount != 8'h0) begin
                        halfCount <= halfCount - 8'h1;
                    end else if (!phaseHigh) begin
                        sclkReg   <= 1'b1;
                        phaseHigh <= 1'b1;
                        halfCount <= 8'(HALF_CYC);
                    end else begin
                        // sample on fall: synchronised miso is too late for the next rise
                        rxByte    <= {rxByte[6:0], misoSync[1]};
                        sclkReg   <= 1'b0;
                        phaseHigh <= 1'b0;
                        halfCount <= 8'(HALF_CYC);
                        txShift   <= {txShift[30:0], 1'b0};
                        bitsLeft  <= bitsLeft - 6'h1;
                        if (bitsLeft == 6'h1) begin
                            csReg    <= 1'b1;
                            state    <= S_GAP;
                            // hold cs high long enough for release or suspend spacing
                            gapCount <= 8'(RECOVER_CYC + SUSPEND_GAP);
                        end
                    end
                end
                S_GAP: begin
                    if (gapCount == 8'h0) begin
                        state <= S_IDLE;
                    end else begin
                        gapCount <= gapCount - 8'h1;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // host sends erase opcodes with no write enable check; software orders them
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regRdata <= '0;
        end else if (regRead) begin
            unique case (regAddr)
                2'h1:    regRdata <= {8'h0, addrReg};
                2'h2:    regRdata <= {23'h0, state != S_IDLE, rxByte};
                default: regRdata <= 32'h0;
            endcase
        end else begin
            regRdata <= 32'h0;
        end
    end

    assign link.csN  = csReg;
    assign link.sclk = sclkReg;
    assign link.mosi = txShift[31];
endmodule : flash_host
`default_nettype wire

// [test/flash_seq_assertions.sv]
// concurrent checks on the flash link and device status
// assumes instantiation in tb_top beside the link interface
`timescale 1ns/100ps
`default_nettype none
module flash_seq_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link wires
    input wire logic csN,
    input wire logic sclk,
    // device status
    input wire logic busy,
    input wire logic writeEnableLatch,
    input wire logic suspendFlag,
    input wire logic poweredDown,
    input wire logic eraseStrobe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_BUSY_AFTER_CS: assert property ($rose(busy) |-> csN)
        else $error("busy rose with chip select low");
    AST_SUS_DROPS_BUSY: assert property ($rose(suspendFlag) |-> ##[0:16] !busy)
        else $error("busy held after suspend");
    AST_SUS_NEEDS_BUSY: assert property ($rose(suspendFlag) |-> $past(busy))
        else $error("suspend taken while idle");
    AST_RESUME_BUSY: assert property ($fell(suspendFlag) |-> ##[0:5] busy)
        else $error("busy late after resume");
    AST_WEL_CLEARED: assert property ($fell(busy) && !suspendFlag |-> ##[0:2] !writeEnableLatch)
        else $error("write enable kept after erase");
    AST_STROBE_ENDS: assert property (eraseStrobe |-> ##[0:2] !busy)
        else $error("busy kept after erase end");
    AST_PD_DEAF: assert property (poweredDown |-> !$rose(writeEnableLatch) && !$rose(busy))
        else $error("command acted on in power-down");
    AST_WEL_AT_CS: assert property ($rose(writeEnableLatch) |-> csN && !sclk)
        else $error("write enable set mid frame");
endmodule : flash_seq_assertions
`default_nettype wire

// [test/tb_top.sv]
// self-checking bench: host and device joined over the link
// assumes default timing constants from flash_seq_params.svh
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_params.svh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
    $display("wrong value %s exp %h got %h", n, e, s); fail_count++; end end
module tb_top;
    import flash_seq_pkg::*;
    logic        clk, sys_rst, regWrite, regRead, busy, writeEnableLatch;
    logic        suspendFlag, poweredDown, eraseStrobe;
    logic [1:0]  regAddr, eraseKind;
    logic [31:0] regWdata, regRdata, blockLocked;
    protect_t    protectBits;
    flash_addr_t eraseAddr, a;
    logic [7:0]  lastRx;
    int          fail_count = 0, tests_run = 0, seed = 32'h5d84;
    logic [7:0]  ops [4] = '{8'h52, 8'hd8, 8'hc7, 8'h60};
    logic [1:0]  kinds [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
    flash_link_if flash_link_if_inst ();
    flash_host flash_host_inst (.clk(clk), .sys_rst(sys_rst), .link(flash_link_if_inst), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
    flash_device flash_device_inst (.clk(clk), .sys_rst(sys_rst), .link(flash_link_if_inst),
        .protectBits(protectBits), .blockLocked(blockLocked), .busy(busy), .writeEnableLatch(writeEnableLatch),
        .suspendFlag(suspendFlag), .poweredDown(poweredDown), .eraseStrobe(eraseStrobe),
        .eraseAddr(eraseAddr), .eraseKind(eraseKind));
    flash_seq_assertions flash_seq_assertions_inst (.clk(clk), .sys_rst(sys_rst),
        .csN(flash_link_if_inst.csN), .sclk(flash_link_if_inst.sclk), .busy(busy),
        .writeEnableLatch(writeEnableLatch), .suspendFlag(suspendFlag), .poweredDown(poweredDown),
        .eraseStrobe(eraseStrobe));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    task automatic wr(input logic [1:0] ad, input logic [31:0] d);
        @(posedge clk);
        regAddr  <= ad;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    // one opcode frame; waits for the frame flag, then decode latency
    task automatic cmd(input logic [7:0] op, input flash_addr_t ad);
        int i;
        wr(2'h1, {8'h00, ad});
        wr(2'h0, {24'h0, op});
        for (i = 0; i < 400; i++) begin
            @(posedge clk);
            regAddr <= 2'h2;
            regRead <= 1'b1;
            @(posedge clk);
            regRead <= 1'b0;
            #1;
            if (regRdata[8] === 1'b0) begin
                lastRx = regRdata[7:0];
                break;
            end
        end
        if (i == 400) begin fail_count++; summarize(); end
        repeat (12) @(posedge clk);
    endtask : cmd
    // bounded wait for idle; erase end pulse captured on the way
    task automatic wait_idle(output logic [1:0] k, output flash_addr_t ad);
        int i;
        k  = 2'h0;
        ad = '0;
        for (i = 0; i < 1000 && busy !== 1'b0; i++) begin
            @(posedge clk);
            #1;
            if (eraseStrobe === 1'b1) begin k = eraseKind; ad = eraseAddr; end
        end
        // strobe rises in the same cycle as the busy fall
        @(posedge clk);
        #1;
        if (eraseStrobe === 1'b1) begin k = eraseKind; ad = eraseAddr; end
        if (i == 1000) begin fail_count++; summarize(); end
    endtask : wait_idle
    initial begin
        logic [1:0]  k;
        flash_addr_t ea;
        sys_rst = 1'b1; regWrite = 1'b0; regRead = 1'b0; regAddr = 2'h0; regWdata = 32'h0;
        protectBits = 6'h00; blockLocked = 32'h0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("poweredDown", 1'b0, poweredDown)
        `CHK("suspendFlag", 1'b0, suspendFlag)
        a = $random(seed);
        cmd(8'h52, a);
        `CHK("busy no wel", 1'b0, busy)
        for (int j = 0; j < 4; j++) begin
            a = $random(seed);
            cmd(8'h06, 24'h0);
            cmd(ops[j], a);
            `CHK("busy", 1'b1, busy)
            cmd(8'h05, 24'h0);
            `CHK("status in erase", 8'h03, lastRx)
            wait_idle(k, ea);
            `CHK("eraseKind", kinds[j], k)
            if (j < 2) `CHK("eraseAddr", a, ea)
            `CHK("wel after", 1'b0, writeEnableLatch)
        end
        $display("test erase done");
        protectBits <= 6'h01;
        cmd(8'h06, 24'h0);
        cmd(8'hd8, a);
        `CHK("busy protected", 1'b0, busy)
        protectBits <= 6'h00;
        blockLocked <= 32'h1 << a[20:16];
        cmd(8'hc7, 24'h0);
        `CHK("busy locked", 1'b0, busy)
        blockLocked <= 32'h0;
        $display("test protect done");
        cmd(8'hd8, a);
        cmd(8'h75, 24'h0);
        repeat (8) @(posedge clk);
        `CHK("suspendFlag", 1'b1, suspendFlag)
        `CHK("busy suspended", 1'b0, busy)
        cmd(8'h52, a ^ 24'h010000);
        `CHK("busy erase in suspend", 1'b0, busy)
        cmd(8'h7a, 24'h0);
        `CHK("suspendFlag resumed", 1'b0, suspendFlag)
        `CHK("busy resumed", 1'b1, busy)
        wait_idle(k, ea);
        `CHK("kind resumed", 2'h2, k)
        cmd(8'h7a, 24'h0);
        `CHK("busy stray resume", 1'b0, busy)
        cmd(8'h06, 24'h0);
        cmd(8'h60, 24'h0);
        cmd(8'h75, 24'h0);
        `CHK("suspend chip", 1'b0, suspendFlag)
        `CHK("busy chip", 1'b1, busy)
        wait_idle(k, ea);
        `CHK("kind chip", 2'h3, k)
        $display("test suspend done");
        cmd(8'hb9, 24'h0);
        `CHK("poweredDown", 1'b1, poweredDown)
        cmd(8'h06, 24'h0);
        `CHK("wel in pd", 1'b0, writeEnableLatch)
        cmd(8'hab, 24'h0);
        cmd(8'h06, 24'h0);
        `CHK("poweredDown", 1'b0, poweredDown)
        `CHK("wel after release", 1'b1, writeEnableLatch)
        $display("test powerdown done");
        summarize();
    end
endmodule : tb_top
`default_nettype wire
